// ---- dv/rpsd_bus_master.sv ----
// Behavioural bus master standing in for the serial protocol engine.
// Assumes the decoder's link port; makes a link clock that stops between accesses.
`timescale 1ns/10ps
`default_nettype none
module rpsd_bus_master (
   input  wire logic                  rst,
   output logic                       link_clk,
   output logic                       link_req,
   output logic                       link_wr,
   output logic                       link_bcast,
   output rpsd_pkg::rpsd_byte_t       link_addr,
   output rpsd_pkg::rpsd_byte_t       link_wdata,
   output rpsd_pkg::rpsd_byte_t       link_wmask,
   input  wire logic                  link_busy,
   input  wire rpsd_pkg::rpsd_byte_t  link_rdata,
   input  wire logic                  link_rvalid
);
   import rpsd_pkg::*;
   logic run;

   // Serial clock runs only in reset and in frames, and always parks low
   initial begin
      link_clk = 1'b0;
      run = 1'b0;
      link_req = 1'b0;
      {link_wr, link_bcast} = 2'b00;
      {link_addr, link_wdata, link_wmask} = {8'h00, 8'h00, 8'h00};
      #3.1;
      forever begin
         #62.5;
         if (run || rst || link_clk) link_clk = ~link_clk;
      end
   end

   // One access: offer, hold until taken, scramble released lines, await answer
   task automatic access(input logic wr, input logic bc, input rpsd_byte_t adr, input rpsd_byte_t dat,
                         input rpsd_byte_t msk, output rpsd_byte_t rd);
      int n;
      n = 0;
      rd = 8'hXX;
      run = 1'b1;
      @(negedge link_clk);
      while (link_busy !== 1'b0) @(negedge link_clk);
      link_req = 1'b1;
      link_wr = wr;
      link_bcast = bc;
      {link_addr, link_wdata, link_wmask} = {adr, dat, msk};
      @(negedge link_clk);
      // Released lines show inverted data so a late sample cannot pass by chance
      link_req = 1'b0;
      {link_wr, link_bcast} = ~{wr, bc};
      {link_addr, link_wdata, link_wmask} = ~{adr, dat, msk};
      do begin
         @(posedge link_clk);
         #1;
         n++;
      end while (link_busy !== 1'b0 && n < 64);
      // Read data and its valid pulse land one link edge after busy falls
      if (!wr) begin
         @(posedge link_clk);
         #1;
         if (link_rvalid === 1'b1) rd = link_rdata;
      end
      @(negedge link_clk);
      run = 1'b0;
   endtask : access
endmodule : rpsd_bus_master
`default_nettype wire

// ---- dv/test_rf_path_select_decoder.sv ----
// Self-checking bench for the path select decoder register bank.
// Assumes the bus master model in rpsd_bus_master.sv and the register map header.
`timescale 1ns/10ps
`default_nettype none
`include "rpsd_map.svh"
module test_rf_path_select_decoder;
   import rpsd_pkg::*;
   logic        ref_clk;
   logic        rst;
   logic        link_clk;
   logic        link_req;
   logic        link_wr;
   logic        link_bcast;
   rpsd_byte_t  link_addr;
   rpsd_byte_t  link_wdata;
   rpsd_byte_t  link_wmask;
   rpsd_byte_t  link_rdata;
   logic        link_busy;
   logic        link_rvalid;
   rpsd_paths_t out_one;
   rpsd_paths_t out_two;
   rpsd_mode_t  route_mode;
   int          fail_count = 0;
   int          cmp_count = 0;
   rpsd_byte_t  codes [10] = '{8'h00, 8'hC1, 8'h13, 8'h26, 8'h23, 8'h3C, 8'h0F, 8'h32, 8'h18, 8'h1C};

   rpsd_path_select_top uut (.ref_clk(ref_clk), .rst(rst), .link_clk(link_clk), .link_req(link_req),
      .link_wr(link_wr), .link_bcast(link_bcast), .link_addr(link_addr), .link_wdata(link_wdata),
      .link_wmask(link_wmask), .link_busy(link_busy), .link_rdata(link_rdata), .link_rvalid(link_rvalid),
      .rf_output_one_sel(out_one), .rf_output_two_sel(out_two), .route_mode(route_mode));
   rpsd_bus_master bm (.rst(rst), .link_clk(link_clk), .link_req(link_req), .link_wr(link_wr),
      .link_bcast(link_bcast), .link_addr(link_addr), .link_wdata(link_wdata), .link_wmask(link_wmask),
      .link_busy(link_busy), .link_rdata(link_rdata), .link_rvalid(link_rvalid));

   task automatic test_done();
      if (fail_count == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : test_done

   task automatic check(input rpsd_byte_t seen, input rpsd_byte_t exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check

   // Independent reading of the three routing tables
   function automatic void ref_dec(input rpsd_byte_t r, input rpsd_byte_t c, input rpsd_byte_t m,
                                   output rpsd_paths_t o1, output rpsd_paths_t o2, output rpsd_mode_t md);
      rpsd_paths_t s, lo, hi, a, b;
      int cnt;
      s = c[3:0];
      lo = s & (~s + 4'h1);
      hi = s & ~lo;
      cnt = $countones(s);
      {a, b, o1, o2} = 16'h0000;
      md = m[0] ? mode_map : (r[0] ? mode_cross : mode_direct);
      if (m[0]) {o2, o1} = c;
      else begin
         if (c[5:4] == 2'b00 && cnt == 1) a = s;
         else if (c[5:4] == 2'b11 && cnt == 1) b = s;
         else if (c[5:4] == 2'b01 && cnt == 2) {a, b} = {lo, hi};
         else if (c[5:4] == 2'b10 && cnt == 2) {a, b} = {hi, lo};
         {o1, o2} = r[0] ? {b, a} : {a, b};
      end
   endfunction : ref_dec

   task automatic wr(input rpsd_byte_t a, input rpsd_byte_t d, input rpsd_byte_t m);
      rpsd_byte_t x;
      bm.access(1'b1, 1'b0, a, d, m, x);
   endtask : wr

   task automatic rd_chk(input rpsd_byte_t a, input rpsd_byte_t e);
      rpsd_byte_t x;
      bm.access(1'b0, 1'b0, a, 8'h00, 8'h00, x);
      check(x, e);
   endtask : rd_chk

   task automatic chk_out(input rpsd_paths_t o1, input rpsd_paths_t o2, input rpsd_mode_t md);
      repeat (4) @(negedge ref_clk);
      check({4'h0, out_one}, {4'h0, o1});
      check({4'h0, out_two}, {4'h0, o2});
      check({6'h00, route_mode}, {6'h00, md});
   endtask : chk_out

   // Load all three switch registers, fire the top extended trigger, judge the paths
   task automatic apply(input rpsd_byte_t r, input rpsd_byte_t c, input rpsd_byte_t m);
      rpsd_paths_t o1, o2;
      rpsd_mode_t  md;
      wr(`RPSD_ADDR_SWITCH_BASE, r, 8'hFF);
      wr(`RPSD_ADDR_SWITCH_BASE + 8'h01, c, 8'hFF);
      wr(`RPSD_ADDR_SWITCH_BASE + 8'h02, m, 8'hFF);
      wr(`RPSD_ADDR_FIRE, 8'h80, 8'hFF);
      ref_dec(r, c, m, o1, o2, md);
      chk_out(o1, o2, md);
      rd_chk(`RPSD_ADDR_SWITCH_BASE + 8'h01, c);
   endtask : apply

   task automatic t_reset();
      chk_out(4'h0, 4'h0, mode_direct);
      rd_chk(`RPSD_ADDR_SWITCH_BASE, `RPSD_RST_SWITCH);
      rd_chk(`RPSD_ADDR_SWITCH_BASE + 8'h02, `RPSD_RST_SWITCH);
      rd_chk(`RPSD_ADDR_GATE, 8'hFF);
      rd_chk(`RPSD_ADDR_FIRE, 8'h00);
   endtask : t_reset

   task automatic t_decode();
      for (int r = 0; r < 2; r++) begin
         foreach (codes[i]) apply(r[7:0], codes[i], 8'h00);
      end
      apply(8'h01, 8'hA5, 8'h01);
      apply(8'h00, 8'hFF, 8'hFF);
   endtask : t_decode

   // Gate holds pending data; zero fire does nothing; broadcast fires but never moves the gate
   task automatic t_trigger();
      rpsd_byte_t x;
      apply(8'h00, 8'h01, 8'h00);
      wr(`RPSD_ADDR_GATE, 8'h00, 8'h01);
      rd_chk(`RPSD_ADDR_GATE, 8'hFE);
      wr(`RPSD_ADDR_SWITCH_BASE + 8'h01, 8'hF0, 8'hF0);
      wr(`RPSD_ADDR_FIRE, 8'h01, 8'hFF);
      chk_out(4'h1, 4'h0, mode_direct);
      wr(`RPSD_ADDR_FIRE, 8'h00, 8'hFF);
      chk_out(4'h1, 4'h0, mode_direct);
      bm.access(1'b1, 1'b1, `RPSD_ADDR_FIRE, 8'h02, 8'hFF, x);
      chk_out(4'h0, 4'h1, mode_direct);
      rd_chk(`RPSD_ADDR_SWITCH_BASE + 8'h01, 8'hF1);
      bm.access(1'b1, 1'b1, `RPSD_ADDR_GATE, 8'hFF, 8'hFF, x);
      rd_chk(`RPSD_ADDR_GATE, 8'hFE);
      rd_chk(`RPSD_ADDR_FIRE, 8'h00);
      rd_chk(8'h10, 8'h00);
      wr(`RPSD_ADDR_GATE, 8'hFF, 8'hFF);
   endtask : t_trigger

   // Core clock at 200 MHz
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   // Reset spans five core cycles and two link edges, so both domains see it
   initial begin
      rst = 1'b1;
      repeat (5) @(negedge ref_clk);
      repeat (2) @(posedge link_clk);
      @(negedge ref_clk);
      rst = 1'b0;
      t_reset();
      t_decode();
      t_trigger();
      test_done();
   end

   // Watchdog well past the expected run of some 70 us
   initial begin
      #400us;
      fail_count++;
      test_done();
   end
endmodule : test_rf_path_select_decoder
`default_nettype wire

// ---- rtl/rpsd_link_port.sv ----
// Link-clock end: takes one register access, toggles it across, awaits answer.
// Assumes the protocol engine holds off while link_busy is high.
`timescale 1ns/10ps
`default_nettype none
module rpsd_link_port (
   input  wire logic                  link_clk,
   input  wire logic                  rst,
   input  wire logic                  link_req,
   input  wire logic                  link_wr,
   input  wire logic                  link_bcast,
   input  wire rpsd_pkg::rpsd_byte_t  link_addr,
   input  wire rpsd_pkg::rpsd_byte_t  link_wdata,
   input  wire rpsd_pkg::rpsd_byte_t  link_wmask,
   output logic                       link_busy,
   output rpsd_pkg::rpsd_byte_t       link_rdata,
   output logic                       link_rvalid,
   rpsd_xfer_if.link                  xfer
);
   import rpsd_pkg::*;
   logic       req_tgl_ff;
   logic       wr_ff;
   logic       bcast_ff;
   rpsd_byte_t addr_ff;
   rpsd_byte_t wdata_ff;
   rpsd_byte_t wmask_ff;
   logic       ack_s1_ff;
   logic       ack_s2_ff;
   logic       ack_s3_ff;
   rpsd_byte_t rdata_ff;
   logic       rvalid_ff;
   // Fields stay frozen until the answer returns, so the core reads them safely
   wire take     = link_req & ~link_busy;
   wire ack_edge = ack_s2_ff ^ ack_s3_ff;
   assign link_busy   = req_tgl_ff ^ ack_s2_ff;
   assign link_rdata  = rdata_ff;
   assign link_rvalid = rvalid_ff;
   assign xfer.req_tgl = req_tgl_ff;
   assign xfer.wr      = wr_ff;
   assign xfer.bcast   = bcast_ff;
   assign xfer.addr    = addr_ff;
   assign xfer.wdata   = wdata_ff;
   assign xfer.wmask   = wmask_ff;
   // Capture a request and flip the toggle
   always_ff @(posedge link_clk or posedge rst) begin
      if (rst) begin
         {req_tgl_ff, wr_ff, bcast_ff} <= 3'h0;
         {addr_ff, wdata_ff, wmask_ff} <= 24'h000000;
      end else if (take) begin
         req_tgl_ff <= ~req_tgl_ff;
         {wr_ff, bcast_ff} <= {link_wr, link_bcast};
         {addr_ff, wdata_ff, wmask_ff} <= {link_addr, link_wdata, link_wmask};
      end
   end
   // Answer toggle synchroniser; read data is stable once the toggle is seen
   always_ff @(posedge link_clk or posedge rst) begin
      if (rst) begin
         {ack_s1_ff, ack_s2_ff, ack_s3_ff, rvalid_ff} <= 4'h0;
         rdata_ff <= 8'h00;
      end else begin
         {ack_s1_ff, ack_s2_ff, ack_s3_ff} <= {xfer.ack_tgl, ack_s1_ff, ack_s2_ff};
         rvalid_ff <= ack_edge & ~wr_ff;
         rdata_ff  <= (ack_edge & ~wr_ff) ? xfer.rdata : rdata_ff;
      end
   end
endmodule : rpsd_link_port
`default_nettype wire

// ---- rtl/rpsd_path_decoder.sv ----
// Combinational decode of the three switch registers into path closures.
// Assumes its inputs are the active (not shadow) register values.
`timescale 1ns/10ps
`default_nettype none
`include "rpsd_map.svh"
module rpsd_path_decoder (
   input  wire rpsd_pkg::rpsd_byte_t  route,
   input  wire rpsd_pkg::rpsd_byte_t  code,
   input  wire rpsd_pkg::rpsd_byte_t  mapen,
   output rpsd_pkg::rpsd_mode_t       mode,
   output rpsd_pkg::rpsd_paths_t      out1,
   output rpsd_pkg::rpsd_paths_t      out2
);
   import rpsd_pkg::*;
   // Only D5:D0 take part in the table modes; D7:D6 are used in mapping mode only
   wire [3:0] sel     = code[`RPSD_SEL_MSB:0];
   wire [1:0] sub     = code[`RPSD_SUB_MSB:`RPSD_SUB_LSB];
   wire [3:0] sel_neg = ~sel + 4'h1;
   wire [3:0] low     = sel & sel_neg;
   wire [3:0] high    = sel ^ low;
   wire [3:0] high_m1 = high - 4'h1;
   wire       one_hot = (sel != 4'h0) && (high == 4'h0);
   wire       two_hot = (high != 4'h0) && ((high & high_m1) == 4'h0);
   // Direct table; anything unlisted (zero code too) falls to isolation
   wire [3:0] d1 = (sub == `RPSD_SUB_OUT1_ONE && one_hot) ? sel :
                   (sub == `RPSD_SUB_PAIR_LOW1 && two_hot) ? low :
                   (sub == `RPSD_SUB_PAIR_HIGH1 && two_hot) ? high : 4'h0;
   wire [3:0] d2 = (sub == `RPSD_SUB_OUT2_ONE && one_hot) ? sel :
                   (sub == `RPSD_SUB_PAIR_LOW1 && two_hot) ? high :
                   (sub == `RPSD_SUB_PAIR_HIGH1 && two_hot) ? low : 4'h0;
   wire       map_on   = mapen[`RPSD_BIT_MAP];
   wire       cross_on = route[`RPSD_BIT_CROSS];
   // Cross mode is the direct table with the outputs swapped
   assign mode = map_on ? mode_map : (cross_on ? mode_cross : mode_direct);
   assign out1 = map_on ? code[`RPSD_SEL_MSB:0] : (cross_on ? d2 : d1);
   assign out2 = map_on ? code[`RPSD_OUT2_MSB:`RPSD_OUT2_LSB] : (cross_on ? d1 : d2);
endmodule : rpsd_path_decoder
`default_nettype wire

// ---- rtl/rpsd_path_select_top.sv ----
// Path select decoder: switch register bank with trigger shadowing,
// the extended trigger and gate registers, and registered path outputs.
// Assumes a protocol engine on link_clk presents one decoded access at a time.
// Behaviour
// - Three zero-reset masked, shadowed switch registers
// - Gate bits reset one; zero holds shadow
// - Fire bit one moves shadow to active
// - Fire bits reset zero; zero does nothing
// - Fire register takes broadcast and masked writes
// - Mapping enable set selects per-path mapping
// - Route bit clear selects direct table
// - Route bit set selects cross table
// - Table modes ignore path code D7:D6
// - Zero path code isolates everything
// - Direct 00: one input to output one
// - Direct 01: lower to one, higher two
// - Direct 10: higher to one, lower two
// - Direct 11: one input to output two
// - Cross 00: one input to output two
// - Cross 01: lower to two, higher one
// - Cross 10: higher to two, lower one
// - Cross 11: one input to output one
// - Map low nibble closes paths to one
// - Map high nibble closes paths to two
// - Map allows any path combination
`timescale 1ns/10ps
`default_nettype none
`include "rpsd_map.svh"

module rpsd_path_select_top (
   input  wire logic                  ref_clk,
   input  wire logic                  rst,
   input  wire logic                  link_clk,
   input  wire logic                  link_req,
   input  wire logic                  link_wr,
   input  wire logic                  link_bcast,
   input  wire rpsd_pkg::rpsd_byte_t  link_addr,
   input  wire rpsd_pkg::rpsd_byte_t  link_wdata,
   input  wire rpsd_pkg::rpsd_byte_t  link_wmask,
   output logic                       link_busy,
   output rpsd_pkg::rpsd_byte_t       link_rdata,
   output logic                       link_rvalid,
   output rpsd_pkg::rpsd_paths_t      rf_output_one_sel,
   output rpsd_pkg::rpsd_paths_t      rf_output_two_sel,
   output rpsd_pkg::rpsd_mode_t       route_mode
);
   import rpsd_pkg::*;

   // Register state on ref_clk
   logic          req_s1_ff;
   logic          req_s2_ff;
   logic          req_s3_ff;
   logic          ack_tgl_ff;
   rpsd_byte_t    rdata_ff;
   rpsd_byte_t    gate_ff;
   rpsd_byte_t    shadow_ff [`RPSD_NUM_SWITCH];
   rpsd_byte_t    active_ff [`RPSD_NUM_SWITCH];
   rpsd_paths_t   out1_ff;
   rpsd_paths_t   out2_ff;
   rpsd_mode_t    mode_ff;
   rpsd_paths_t   dec_out1;
   rpsd_paths_t   dec_out2;
   rpsd_mode_t    dec_mode;
   logic [2:0]    hit_sw;
   logic [2:0]    wr_sw;

   rpsd_xfer_if xfer ();

   // Link-clock end of the crossing
   rpsd_link_port u_link (
      .link_clk    (link_clk),
      .rst         (rst),
      .link_req    (link_req),
      .link_wr     (link_wr),
      .link_bcast  (link_bcast),
      .link_addr   (link_addr),
      .link_wdata  (link_wdata),
      .link_wmask  (link_wmask),
      .link_busy   (link_busy),
      .link_rdata  (link_rdata),
      .link_rvalid (link_rvalid),
      .xfer        (xfer.link)
   );

   // Request toggle synchroniser; stage one feeds stage two only
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         {req_s1_ff, req_s2_ff, req_s3_ff} <= 3'h0;
      end else begin
         {req_s1_ff, req_s2_ff, req_s3_ff} <= {xfer.req_tgl, req_s1_ff, req_s2_ff};
      end
   end

   // Access decode; the link fields are frozen while a request is open
   wire req_edge = req_s2_ff ^ req_s3_ff;
   wire wr_take  = req_edge & xfer.wr;
   wire rd_take  = req_edge & ~xfer.wr;
   wire uni_wr   = wr_take & ~xfer.bcast;
   wire hit_gate = (xfer.addr == `RPSD_ADDR_GATE);
   wire hit_fire = (xfer.addr == `RPSD_ADDR_FIRE);
   // Broadcast and group writes reach only the fire register, never the gate
   wire wr_gate  = uni_wr & hit_gate;
   wire wr_fire  = wr_take & hit_fire;

   // Fire bits are pulses: a one fires, a zero is no action
   wire [7:0] fire_vec = wr_fire ? (xfer.wdata & xfer.wmask) : 8'h00;
   // A gate bit at zero keeps the shadow data waiting
   wire       xfer_go  = |(fire_vec & gate_ff);
   wire [7:0] gate_mw  = (gate_ff & ~xfer.wmask) | (xfer.wdata & xfer.wmask);
   wire [7:0] nxt_gate = wr_gate ? gate_mw : gate_ff;

   // Gate register, all bits open after reset
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         gate_ff <= `RPSD_RST_GATE;
      end else begin
         gate_ff <= nxt_gate;
      end
   end

   // Switch registers: writes land in the shadow, triggers move them on
   genvar gi;
   generate
      for (gi = 0; gi < `RPSD_NUM_SWITCH; gi++) begin : g_sw
         wire [7:0] sw_addr    = `RPSD_ADDR_SWITCH_BASE + 8'(gi);
         wire [7:0] sw_mw      = (shadow_ff[gi] & ~xfer.wmask) | (xfer.wdata & xfer.wmask);
         wire [7:0] nxt_shadow = wr_sw[gi] ? sw_mw : shadow_ff[gi];
         wire [7:0] nxt_active = xfer_go ? shadow_ff[gi] : active_ff[gi];
         assign hit_sw[gi] = (xfer.addr == sw_addr);
         assign wr_sw[gi]  = uni_wr & hit_sw[gi];
         always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
               shadow_ff[gi] <= `RPSD_RST_SWITCH;
               active_ff[gi] <= `RPSD_RST_SWITCH;
            end else begin
               shadow_ff[gi] <= nxt_shadow;
               active_ff[gi] <= nxt_active;
            end
         end
      end
   endgenerate

   // Read selection; fire reads zero since its bits never stay set
   wire [7:0] rd_sw = hit_sw[`RPSD_IDX_ROUTE] ? active_ff[`RPSD_IDX_ROUTE] :
                      hit_sw[`RPSD_IDX_CODE]  ? active_ff[`RPSD_IDX_CODE]  :
                      hit_sw[`RPSD_IDX_MAPEN] ? active_ff[`RPSD_IDX_MAPEN] : `RPSD_READ_ZERO;
   wire [7:0] nxt_rdata = xfer.bcast ? `RPSD_READ_ZERO :
                          hit_gate ? gate_ff : rd_sw;

   // Answer: read data and the toggle move together, data settles first at the far side
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rdata_ff   <= `RPSD_READ_ZERO;
         ack_tgl_ff <= 1'b0;
      end else begin
         rdata_ff   <= rd_take ? nxt_rdata : rdata_ff;
         ack_tgl_ff <= ack_tgl_ff ^ req_edge;
      end
   end

   assign xfer.ack_tgl = ack_tgl_ff;
   assign xfer.rdata   = rdata_ff;

   // Path decode from the active copies only
   rpsd_path_decoder u_dec (
      .route (active_ff[`RPSD_IDX_ROUTE]),
      .code  (active_ff[`RPSD_IDX_CODE]),
      .mapen (active_ff[`RPSD_IDX_MAPEN]),
      .mode  (dec_mode),
      .out1  (dec_out1),
      .out2  (dec_out2)
   );

   // Registered path controls; glitch-free drive for the RF switch cells
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         out1_ff <= 4'h0;
         out2_ff <= 4'h0;
         mode_ff <= mode_direct;
      end else begin
         out1_ff <= dec_out1;
         out2_ff <= dec_out2;
         mode_ff <= dec_mode;
      end
   end

   assign rf_output_one_sel = out1_ff;
   assign rf_output_two_sel = out2_ff;
   assign route_mode        = mode_ff;

   // Helper views for the checks below
   wire [7:0] act_route = active_ff[`RPSD_IDX_ROUTE];
   wire [7:0] act_code  = active_ff[`RPSD_IDX_CODE];
   wire [7:0] act_mapen = active_ff[`RPSD_IDX_MAPEN];
   wire [1:0] act_sub   = act_code[`RPSD_SUB_MSB:`RPSD_SUB_LSB];
   wire [3:0] act_sel   = act_code[`RPSD_SEL_MSB:0];
   wire       is_map    = act_mapen[`RPSD_BIT_MAP];
   wire       is_cross  = ~is_map & act_route[`RPSD_BIT_CROSS];
   wire       is_direct = ~is_map & ~act_route[`RPSD_BIT_CROSS];
   wire [23:0] act_all  = {act_route, act_code, act_mapen};

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   // A switch write never reaches the active copy by itself
   shadow_only_a : assert property (wr_sw[`RPSD_IDX_CODE] |=> $stable(act_code))
      else $error("switch write changed the active register directly");

   // Bits outside the write mask keep their old value
   masked_keep_a : assert property (wr_sw[`RPSD_IDX_ROUTE]
      |=> ((shadow_ff[`RPSD_IDX_ROUTE] ^ $past(shadow_ff[`RPSD_IDX_ROUTE])) & ~$past(xfer.wmask)) == 8'h00)
      else $error("masked write disturbed a protected bit");

   // An open gate plus a fire bit moves shadow into active
   fire_move_a : assert property ((wr_fire && ((xfer.wdata & xfer.wmask & gate_ff) != 8'h00))
      |=> act_code == $past(shadow_ff[`RPSD_IDX_CODE]) && act_route == $past(shadow_ff[`RPSD_IDX_ROUTE]))
      else $error("trigger did not transfer shadow data");

   // Fire bits whose gates are closed leave the active copies alone
   gate_hold_a : assert property ((wr_fire && ((xfer.wdata & xfer.wmask & gate_ff) == 8'h00))
      |=> $stable(act_all))
      else $error("closed gate let shadow data through");

   // A fire write of zeros is no action at all
   zero_fire_a : assert property ((wr_fire && ((xfer.wdata & xfer.wmask) == 8'h00))
      |=> $stable(act_all) ##1 $stable(act_all))
      else $error("zero fire write moved data");

   // Broadcast writes never touch the gate bits
   bcast_gate_a : assert property ((wr_take && xfer.bcast && hit_gate) |=> $stable(gate_ff))
      else $error("broadcast write changed the gate register");

   // Mapping mode: each nibble closes its paths directly
   map_paths_a : assert property (is_map
      |=> rf_output_one_sel == $past(act_code[`RPSD_SEL_MSB:0])
          && rf_output_two_sel == $past(act_code[`RPSD_OUT2_MSB:`RPSD_OUT2_LSB])
          && route_mode == mode_map)
      else $error("mapping mode paths wrong");

   // Direct single input to output one
   direct_single_a : assert property ((is_direct && act_sub == `RPSD_SUB_OUT1_ONE && $onehot(act_sel))
      |=> rf_output_one_sel == $past(act_sel) && rf_output_two_sel == 4'h0)
      else $error("direct single path wrong");

   // Direct pair: lower input on output one
   direct_pair_a : assert property ((is_direct && act_sub == `RPSD_SUB_PAIR_LOW1 && $countones(act_sel) == 2)
      |=> rf_output_one_sel != 4'h0 && rf_output_one_sel < rf_output_two_sel
          && (rf_output_one_sel | rf_output_two_sel) == $past(act_sel))
      else $error("direct pair ordering wrong");

   // Cross mode mirror of direct 11: single input to output one
   cross_single_a : assert property ((is_cross && act_sub == `RPSD_SUB_OUT2_ONE && $onehot(act_sel))
      |=> rf_output_one_sel == $past(act_sel) && rf_output_two_sel == 4'h0
          && route_mode == mode_cross)
      else $error("cross single path wrong");

   // Cross pair 10: higher input on output two
   cross_pair_a : assert property ((is_cross && act_sub == `RPSD_SUB_PAIR_HIGH1 && $countones(act_sel) == 2)
      |=> rf_output_two_sel > rf_output_one_sel && rf_output_one_sel != 4'h0)
      else $error("cross pair ordering wrong");

   // Direct pair 10: higher input on output one
   direct_high_a : assert property ((is_direct && act_sub == `RPSD_SUB_PAIR_HIGH1 && $countones(act_sel) == 2)
      |=> rf_output_one_sel > rf_output_two_sel && rf_output_two_sel != 4'h0
          && (rf_output_one_sel | rf_output_two_sel) == $past(act_sel))
      else $error("direct high pair ordering wrong");

   // Direct 11: single input to output two only
   direct_out2_a : assert property ((is_direct && act_sub == `RPSD_SUB_OUT2_ONE && $onehot(act_sel))
      |=> rf_output_two_sel == $past(act_sel) && rf_output_one_sel == 4'h0)
      else $error("direct output two single path wrong");

   // Cross 00: single input to output two only
   cross_out2_a : assert property ((is_cross && act_sub == `RPSD_SUB_OUT1_ONE && $onehot(act_sel))
      |=> rf_output_two_sel == $past(act_sel) && rf_output_one_sel == 4'h0
          && route_mode == mode_cross)
      else $error("cross output two single path wrong");

   // Cross 01: lower input on output two
   cross_low_a : assert property ((is_cross && act_sub == `RPSD_SUB_PAIR_LOW1 && $countones(act_sel) == 2)
      |=> rf_output_two_sel < rf_output_one_sel && rf_output_two_sel != 4'h0
          && (rf_output_one_sel | rf_output_two_sel) == $past(act_sel))
      else $error("cross low pair ordering wrong");

   // In the table modes, zero codes and codes with more than two inputs isolate both outputs
   iso_code_a : assert property ((!is_map && (act_sel == 4'h0 || $countones(act_sel) > 2))
      |=> rf_output_one_sel == 4'h0 && rf_output_two_sel == 4'h0)
      else $error("isolation code left a path closed");

   // Path outputs hold while the active registers hold
   output_stable_a : assert property ($stable(act_all)
      |=> $stable(rf_output_one_sel) && $stable(rf_output_two_sel))
      else $error("path outputs moved without a register update");

   // Main scenarios
   fire_xfer_c  : cover property (xfer_go ##1 act_code != $past(act_code));
   map_multi_c  : cover property (is_map && $countones(act_sel) > 1);
   cross_pair_c : cover property (is_cross && act_sub == `RPSD_SUB_PAIR_LOW1 && $countones(act_sel) == 2);
   bcast_fire_c : cover property (wr_fire && xfer.bcast && xfer_go);

endmodule : rpsd_path_select_top
`default_nettype wire

// ---- shared/rpsd_map.svh ----
// Register offsets, field positions and reset values of the path decoder.
// Assumes inclusion by bare name from every file that decodes the map.
`ifndef RPSD_MAP_SVH
`define RPSD_MAP_SVH
`define RPSD_ADDR_SWITCH_BASE 8'h00
`define RPSD_ADDR_GATE        8'h2D
`define RPSD_ADDR_FIRE        8'h2E
`define RPSD_IDX_ROUTE        0
`define RPSD_IDX_CODE         1
`define RPSD_IDX_MAPEN        2
`define RPSD_NUM_SWITCH       3
`define RPSD_RST_SWITCH       8'h00
`define RPSD_RST_GATE         8'hFF
`define RPSD_READ_ZERO        8'h00
`define RPSD_BIT_CROSS        0
`define RPSD_BIT_MAP          0
`define RPSD_SEL_MSB          3
`define RPSD_SUB_MSB          5
`define RPSD_SUB_LSB          4
`define RPSD_OUT2_MSB         7
`define RPSD_OUT2_LSB         4
`define RPSD_SUB_OUT1_ONE     2'b00
`define RPSD_SUB_PAIR_LOW1    2'b01
`define RPSD_SUB_PAIR_HIGH1   2'b10
`define RPSD_SUB_OUT2_ONE     2'b11
`endif

// ---- shared/rpsd_pkg.sv ----
// Types shared by the path decoder modules.
// Assumes nothing beyond a SystemVerilog compiler.
package rpsd_pkg;
   typedef logic [7:0] rpsd_byte_t;
   typedef logic [3:0] rpsd_paths_t;
   typedef enum logic [1:0] {mode_direct, mode_cross, mode_map} rpsd_mode_t;
endpackage : rpsd_pkg

// ---- shared/rpsd_xfer_if.sv ----
// Carrier between the link-clock port and the core register bank.
// Assumes toggle signalling: one request toggle, one answer toggle.
`timescale 1ns/10ps
`default_nettype none
interface rpsd_xfer_if;
   logic                req_tgl;
   logic                wr;
   logic                bcast;
   rpsd_pkg::rpsd_byte_t addr;
   rpsd_pkg::rpsd_byte_t wdata;
   rpsd_pkg::rpsd_byte_t wmask;
   logic                ack_tgl;
   rpsd_pkg::rpsd_byte_t rdata;
   modport link (output req_tgl, wr, bcast, addr, wdata, wmask, input ack_tgl, rdata);
   modport core (input req_tgl, wr, bcast, addr, wdata, wmask, output ack_tgl, rdata);
endinterface : rpsd_xfer_if
`default_nettype wire
